// File: core/exec_stall_ctrl.sv
// Execute stage stall control and data access alignment
`timescale 1ns/1ns
module exec_stall_ctrl
	import pipe_pkg::*;
(
	input  wire logic        clk,         // Instruction clock
	input  wire logic        rst_b,       // Synchronous reset, low
	input  wire logic        exStart,     // First cycle of instruction
	input  wire logic        exLast,      // Final cycle of instruction
	input  wire logic        exPgmRd,     // Instruction reads program space
	input  wire logic [3:0]  exDstReg,    // Destination address register
	input  amode_t           exDstMode,   // Destination addressing form
	input  ikind_t           exKind,      // Instruction class
	input  wire logic [15:0] exPtrVal,    // Destination pointer value
	input  wire logic        pfValid,     // Prefetched instruction valid
	input  wire logic [3:0]  pfSrcReg,    // Prefetched source register
	input  amode_t           pfSrcMode,   // Prefetched source form
	input  wire logic        accValid,    // Data access request
	input  wire logic        accWrite,    // Request is a write
	input  wire logic        accByte,     // Request is byte mode
	input  wire logic [15:0] accAddr,     // Request byte address
	input  wire logic [15:0] accWdata,    // Request store data
	input  wire logic [15:0] regOld,      // Old destination register
	input  wire logic [15:0] aluRes,      // Operation result
	input  wire logic [15:0] memRdata,    // Memory read word
	output logic             holdFetch,   // Stall: hold fetch and PC
	output logic             memEn,       // Memory access strobe
	output logic             memWe,       // Memory write enable
	output logic [15:0]      memAddr,     // Memory word address
	output logic [1:0]       memBe,       // Memory byte lanes
	output logic [15:0]      memWdata,    // Memory store data
	output logic             rdValid,     // Read data ready
	output logic [15:0]      rdData,      // Read data
	output logic [15:0]      regWrData,   // Register write value
	output logic             flagZ,       // Zero flag
	output logic             flagN,       // Negative flag
	output logic             addrErrTrap  // Address error trap pulse
);

	typedef struct packed {
		logic        hold;
		logic        stalled;
		logic        pgmPrev;
		logic [1:0]  cyc;
		logic        trapPend;
		logic        trap;
		logic        memEn;
		logic        memWe;
		logic [15:0] memAddr;
		logic [1:0]  memBe;
		logic [15:0] memWdata;
		logic        rd1;
		logic        rd1Hi;
		logic        rd1Byte;
		logic        rd2;
		logic        rd2Hi;
		logic        rd2Byte;
		logic        rdValid;
		logic [15:0] rdData;
		logic [15:0] regWr;
		logic        fZ;
		logic        fN;
	} state_t;

	state_t      cur_ff;
	state_t      nxt_cur;

	hz_if        hz ();

	logic        hzHit;
	logic        aMis;
	logic        aWe;
	logic [15:0] aAddr;
	logic [1:0]  aBe;
	logic [15:0] aWdata;
	logic [15:0] aRegWr;
	logic        aZ;
	logic        aN;
	logic [1:0]  cycNow;
	logic        stalledNow;
	logic        trig;
	logic        fire;
	logic        endNow;
	logic        misNow;

	// Present the two instructions to the comparator
	assign hz.dstReg   = exDstReg;
	assign hz.dstMode  = exDstMode;
	assign hz.kind     = exKind;
	assign hz.ptrVal   = exPtrVal;
	assign hz.srcValid = pfValid;
	assign hz.srcReg   = pfSrcReg;
	assign hz.srcMode  = pfSrcMode;
	assign hzHit       = hz.hit;

	hazard_cmp u_cmp (
		.hz (hz)
	);

	align_unit u_align (
		.accByte   (accByte),
		.accWrite  (accWrite),
		.accAddr   (accAddr),
		.accWdata  (accWdata),
		.regOld    (regOld),
		.aluRes    (aluRes),
		.misalign  (aMis),
		.memWe     (aWe),
		.memAddr   (aAddr),
		.memBe     (aBe),
		.memWdata  (aWdata),
		.regWrData (aRegWr),
		.flagZ     (aZ),
		.flagN     (aN)
	);

	// Next state: stall timing, trap deferral, memory and read pipes
	always_comb begin
		nxt_cur = cur_ff;
		cycNow = exStart ? RST_CYC : cur_ff.cyc;
		stalledNow = exStart ? 1'b0 : cur_ff.stalled;
		// Post program-space instruction stalls in its second cycle
		trig = cur_ff.pgmPrev ? (cycNow == PGM_STALL_CYC)
			: exLast;
		// No gating by exceptions or loop state: timing stays fixed
		fire = trig && hzHit && !stalledNow;
		nxt_cur.hold = fire;
		nxt_cur.stalled = stalledNow || fire;
		nxt_cur.cyc = (cycNow == CYC_MAX) ? CYC_MAX
			: cycNow + 2'h1;
		endNow = exLast && !fire;
		if (endNow) begin
			nxt_cur.pgmPrev = exPgmRd;
		end
		// Misaligned access traps only once the instruction ends
		misNow = accValid && aMis;
		nxt_cur.trap = endNow && (cur_ff.trapPend || misNow);
		nxt_cur.trapPend = (cur_ff.trapPend || misNow) && !endNow;
		// Memory command; misaligned writes are dropped whole
		nxt_cur.memEn = accValid && (!accWrite || aWe);
		nxt_cur.memWe = accValid && aWe;
		if (accValid) begin
			nxt_cur.memAddr = aAddr;
			nxt_cur.memBe = aBe;
			nxt_cur.memWdata = aWdata;
			nxt_cur.regWr = aRegWr;
			nxt_cur.fZ = aZ;
			nxt_cur.fN = aN;
		end
		// Read pipe: command, then memory answer, then data out
		nxt_cur.rd1 = accValid && !accWrite;
		nxt_cur.rd1Hi = accAddr[0];
		nxt_cur.rd1Byte = accByte;
		nxt_cur.rd2 = cur_ff.rd1;
		nxt_cur.rd2Hi = cur_ff.rd1Hi;
		nxt_cur.rd2Byte = cur_ff.rd1Byte;
		nxt_cur.rdValid = cur_ff.rd2;
		if (cur_ff.rd2) begin
			if (cur_ff.rd2Byte) begin
				nxt_cur.rdData = cur_ff.rd2Hi
					? {8'h00, memRdata[15:8]}
					: {8'h00, memRdata[7:0]};
			end else begin
				nxt_cur.rdData = memRdata;
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// Outputs straight from the state register
	assign holdFetch   = cur_ff.hold;
	assign memEn       = cur_ff.memEn;
	assign memWe       = cur_ff.memWe;
	assign memAddr     = cur_ff.memAddr;
	assign memBe       = cur_ff.memBe;
	assign memWdata    = cur_ff.memWdata;
	assign rdValid     = cur_ff.rdValid;
	assign rdData      = cur_ff.rdData;
	assign regWrData   = cur_ff.regWr;
	assign flagZ       = cur_ff.fZ;
	assign flagN       = cur_ff.fN;
	assign addrErrTrap = cur_ff.trap;

	// A stall never runs two cycles
	AST_STALL_ONE: assert property (@(posedge clk) disable iff (!rst_b)
		holdFetch |=> !holdFetch)
		else $error("stall lasted more than one cycle");

	// Direct write followed by pointer use stalls at instruction end
	AST_DIRECT_PTR: assert property (@(posedge clk) disable iff (!rst_b)
		(exLast && exStart && !cur_ff.pgmPrev && pfValid
		&& exKind == IK_PLAIN && exDstMode == AM_DIRECT
		&& pfSrcMode == AM_IND_MOD && exDstReg == pfSrcReg)
		|=> holdFetch)
		else $error("direct write then pointer use did not stall");

	// Register-value sources never stall
	AST_VALUE_SRC: assert property (@(posedge clk) disable iff (!rst_b)
		pfSrcMode == AM_DIRECT |-> !hzHit)
		else $error("direct source flagged a hazard");

	// Modified indirect destination followed by indirect source
	AST_MOD_PTR: assert property (@(posedge clk) disable iff (!rst_b)
		(exKind == IK_PLAIN && exDstMode == AM_IND_MOD && pfValid
		&& pfSrcMode == AM_IND && exDstReg == pfSrcReg) |-> hzHit)
		else $error("modified pointer hazard missed");

	// Plain indirect stalls only on the self-mapped address
	AST_MAP_PTR: assert property (@(posedge clk) disable iff (!rst_b)
		(exKind == IK_PLAIN && exDstMode == AM_IND && pfValid
		&& pfSrcMode == AM_IND && exDstReg == pfSrcReg)
		|-> hzHit == (exPtrVal == {11'h000, exDstReg, 1'b0}))
		else $error("self-mapped pointer decision wrong");

	// Calls collide with indirect stack pointer source reads
	AST_CALL_SP: assert property (@(posedge clk) disable iff (!rst_b)
		(exKind == IK_CALL && pfValid && pfSrcReg == STACK_PTR_REG
		&& pfSrcMode == AM_IND_MOD) |-> hzHit)
		else $error("call stack pointer hazard missed");

	// Jumps and returns never stall
	AST_FLOW_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
		(exKind == IK_JUMP || exKind == IK_RET) |-> !hzHit)
		else $error("jump or return flagged a hazard");

	// After a program-space access the stall comes in cycle two
	AST_PGM_SECOND: assert property (@(posedge clk) disable iff (!rst_b)
		(cur_ff.pgmPrev && !exStart && cur_ff.cyc == PGM_STALL_CYC
		&& hzHit && !cur_ff.stalled) |=> holdFetch)
		else $error("post program-space stall not in cycle two");

	// Trap pulses only right after an instruction end
	AST_TRAP_END: assert property (@(posedge clk) disable iff (!rst_b)
		addrErrTrap |-> $past(exLast))
		else $error("address trap outside instruction end");

	// Odd word read still goes out, on the even address
	AST_MIS_READ: assert property (@(posedge clk) disable iff (!rst_b)
		(accValid && !accWrite && !accByte && accAddr[0])
		|=> memEn && !memWe && !memAddr[0])
		else $error("misaligned read not forced even");

	// Odd word write is dropped
	AST_MIS_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
		(accValid && accWrite && !accByte && accAddr[0])
		|=> !memEn && !memWe)
		else $error("misaligned write reached memory");

	// Byte access drives only the addressed lane
	AST_BYTE_LANE: assert property (@(posedge clk) disable iff (!rst_b)
		(accValid && accByte)
		|=> memBe == ($past(accAddr[0]) ? BE_HI : BE_LO))
		else $error("byte access drove wrong lane");

	// Byte register write keeps the high byte
	AST_BYTE_MERGE: assert property (@(posedge clk) disable iff (!rst_b)
		(accValid && accByte)
		|=> regWrData[15:8] == $past(regOld[15:8]))
		else $error("byte write changed the high byte");

	// Byte flags follow the 8-bit result
	AST_BYTE_FLAGS: assert property (@(posedge clk) disable iff (!rst_b)
		(accValid && accByte)
		|=> flagZ == ($past(aluRes[7:0]) == 8'h00)
		&& flagN == $past(aluRes[7]))
		else $error("byte flags not from 8-bit result");

endmodule : exec_stall_ctrl

// File: core/pipe_pkg.sv
// Shared types and constants for the stall and data access logic
package pipe_pkg;

	// Addressing form of an operand that uses a working register
	typedef enum logic [1:0] {
		AM_NONE,
		AM_DIRECT,
		AM_IND,
		AM_IND_MOD
	} amode_t;

	// Instruction class as far as hazards care
	typedef enum logic [1:0] {
		IK_PLAIN,
		IK_CALL,
		IK_JUMP,
		IK_RET
	} ikind_t;

	// The stack pointer register index
	localparam logic [3:0]  STACK_PTR_REG = 4'hf;
	// Working registers are mapped at index times two in data space
	localparam int          REG_MAP_SHIFT = 1;
	// Extra cycles added by one stall
	localparam logic [1:0]  STALL_CYCLES  = 2'h1;
	// Cycle index at which a post-program-space instruction stalls
	localparam logic [1:0]  PGM_STALL_CYC = 2'h1;
	localparam logic [1:0]  CYC_MAX       = 2'h3;
	// Byte lane enables, bit 0 is the even (lower) address
	localparam logic [1:0]  BE_LO         = 2'h1;
	localparam logic [1:0]  BE_HI         = 2'h2;
	localparam logic [1:0]  BE_WORD       = 2'h3;
	// Values after reset
	localparam logic [15:0] RST_WORD      = 16'h0000;
	localparam logic [1:0]  RST_CYC       = 2'h0;

endpackage : pipe_pkg

// File: core/hz_if.sv
// Descriptor link between the control core and the hazard comparator
`timescale 1ns/1ns
interface hz_if;
	import pipe_pkg::*;
	logic [3:0]  dstReg;
	amode_t      dstMode;
	ikind_t      kind;
	logic [15:0] ptrVal;
	logic        srcValid;
	logic [3:0]  srcReg;
	amode_t      srcMode;
	logic        hit;
	modport core (output dstReg, dstMode, kind, ptrVal, srcValid,
		srcReg, srcMode, input hit);
	modport cmp (input dstReg, dstMode, kind, ptrVal, srcValid,
		srcReg, srcMode, output hit);
endinterface : hz_if

// File: core/hazard_cmp.sv
// Read-after-write address register comparator
`timescale 1ns/1ns
module hazard_cmp
	import pipe_pkg::*;
(
	hz_if.cmp hz // Descriptors in, hit out
);
	logic        same;
	logic        srcInd;
	logic [15:0] mapAddr;

	// Decide whether the prefetched source depends on the pending write
	always_comb begin
		mapAddr = {12'h000, hz.dstReg} << REG_MAP_SHIFT;
		same = hz.srcValid && hz.dstMode != AM_NONE
			&& hz.srcMode != AM_NONE && hz.dstReg == hz.srcReg;
		srcInd = hz.srcMode == AM_IND || hz.srcMode == AM_IND_MOD;
		hz.hit = 1'b0;
		if (hz.kind == IK_CALL) begin
			// Calls push through the stack pointer
			hz.hit = hz.srcValid && srcInd
				&& hz.srcReg == STACK_PTR_REG;
		end else if (hz.kind == IK_PLAIN && same && srcInd) begin
			unique case (hz.dstMode)
				AM_DIRECT:  hz.hit = 1'b1;
				AM_IND_MOD: hz.hit = 1'b1;
				AM_IND:     hz.hit = hz.ptrVal == mapAddr;
				AM_NONE:    hz.hit = 1'b0;
			endcase
		end
		// Jumps and returns write no working register
	end

endmodule : hazard_cmp

// File: core/align_unit.sv
// Byte and word operand steering with alignment checking
`timescale 1ns/1ns
module align_unit
	import pipe_pkg::*;
(
	input  wire logic        accByte,   // Byte mode access
	input  wire logic        accWrite,  // Access is a write
	input  wire logic [15:0] accAddr,   // Byte address
	input  wire logic [15:0] accWdata,  // Data to store
	input  wire logic [15:0] regOld,    // Current destination register
	input  wire logic [15:0] aluRes,    // Operation result
	output logic             misalign,  // Odd word address
	output logic             memWe,     // Write allowed
	output logic [15:0]      memAddr,   // Even word address
	output logic [1:0]       memBe,     // Byte lanes
	output logic [15:0]      memWdata,  // Lane-placed data
	output logic [15:0]      regWrData, // Merged register write
	output logic             flagZ,     // Zero flag
	output logic             flagN      // Negative flag
);

	// Steer lanes, merge register bytes and derive flags
	always_comb begin
		misalign = !accByte && accAddr[0];
		memAddr = {accAddr[15:1], 1'b0};
		memWe = accWrite && !misalign;
		if (accByte) begin
			memBe = accAddr[0] ? BE_HI : BE_LO;
			memWdata = {accWdata[7:0], accWdata[7:0]};
			regWrData = {regOld[15:8], aluRes[7:0]};
			flagZ = aluRes[7:0] == 8'h00;
			flagN = aluRes[7];
		end else begin
			memBe = BE_WORD;
			memWdata = accWdata;
			regWrData = aluRes;
			flagZ = aluRes == 16'h0000;
			flagN = aluRes[15];
		end
	end

endmodule : align_unit

// File: tb/data_mem_model.sv
// Byte-lane synchronous data memory on the far side of the access port
`timescale 1ns/1ns
module data_mem_model (
	input  wire logic        clk,      // Instruction clock
	input  wire logic        memEn,    // Access strobe
	input  wire logic        memWe,    // Write enable
	input  wire logic [15:0] memAddr,  // Even word address
	input  wire logic [1:0]  memBe,    // Byte lanes
	input  wire logic [15:0] memWdata, // Store data
	output logic      [15:0] memRdata  // Read word, one cycle later
);
	logic [15:0] words [0:255];
	logic [15:0] rd;
	logic        rdOk;

	initial begin
		rd = 16'h0000;
		rdOk = 1'b0;
	end

	// Lane 0 is the even byte, lane 1 the odd byte above it
	always @(posedge clk) begin
		rdOk <= memEn && !memWe;
		if (memEn && memWe && memBe[0]) begin
			words[memAddr[8:1]][7:0] <= memWdata[7:0];
		end
		if (memEn && memWe && memBe[1]) begin
			words[memAddr[8:1]][15:8] <= memWdata[15:8];
		end
		if (memEn && !memWe) begin
			rd <= words[memAddr[8:1]];
		end
	end

	// Outside the valid cycle the bus shows garbage, not stale data
	assign memRdata = rdOk ? rd : ~rd;
endmodule : data_mem_model

// File: tb/raw_stall_and_byte_word_access_tb.sv
// Self-checking bench for stall control and byte/word data access
`timescale 1ns/1ns
module raw_stall_and_byte_word_access_tb;
	import pipe_pkg::*;
	logic        clk, rst_b, exStart, exLast, exPgmRd, pfValid;
	logic [3:0]  exDstReg, pfSrcReg;
	amode_t      exDstMode, pfSrcMode;
	ikind_t      exKind;
	logic [15:0] exPtrVal, accAddr, accWdata, regOld, aluRes, memRdata;
	logic        accValid, accWrite, accByte;
	logic        holdFetch, memEn, memWe, rdValid, flagZ, flagN, addrErrTrap;
	logic [15:0] memAddr, memWdata, rdData, regWrData;
	logic [1:0]  memBe;
	int          mismatches, compares, cycles;

	exec_stall_ctrl dut (.clk(clk), .rst_b(rst_b), .exStart(exStart),
		.exLast(exLast), .exPgmRd(exPgmRd), .exDstReg(exDstReg),
		.exDstMode(exDstMode), .exKind(exKind), .exPtrVal(exPtrVal),
		.pfValid(pfValid), .pfSrcReg(pfSrcReg), .pfSrcMode(pfSrcMode),
		.accValid(accValid), .accWrite(accWrite), .accByte(accByte),
		.accAddr(accAddr), .accWdata(accWdata), .regOld(regOld),
		.aluRes(aluRes), .memRdata(memRdata), .holdFetch(holdFetch),
		.memEn(memEn), .memWe(memWe), .memAddr(memAddr), .memBe(memBe),
		.memWdata(memWdata), .rdValid(rdValid), .rdData(rdData),
		.regWrData(regWrData), .flagZ(flagZ), .flagN(flagN),
		.addrErrTrap(addrErrTrap));

	data_mem_model mem (.clk(clk), .memEn(memEn), .memWe(memWe),
		.memAddr(memAddr), .memBe(memBe), .memWdata(memWdata),
		.memRdata(memRdata));

	// Clock generation
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task end_of_test;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			end_of_test;
		end
	end

	task check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Stall expected from the dependency table
	function automatic logic exp_hit(input logic [3:0] d, input amode_t dm,
		input ikind_t k, input logic [15:0] p, input logic [3:0] s,
		input amode_t sm);
		logic ind;
		ind = (sm == AM_IND) || (sm == AM_IND_MOD);
		if (k == IK_JUMP || k == IK_RET) return 1'b0;
		if (k == IK_CALL) return ind && s == STACK_PTR_REG;
		if (s != d || !ind) return 1'b0;
		return dm == AM_DIRECT || dm == AM_IND_MOD ||
			(dm == AM_IND && p == (16'(d) << REG_MAP_SHIFT));
	endfunction : exp_hit

	// Runs an n-cycle instruction; st is the cycle whose edge stalls
	task run_ins(input int n, input int st);
		int ext;
		int lastAt;
		ext = (st >= 0) ? 1 : 0;
		lastAt = (st == n - 1) ? n - 1 : n - 1 + ext;
		for (int i = 0; i < n + ext; i++) begin
			exStart = (i == 0);
			exLast = (i >= lastAt);
			@(posedge clk);
			@(negedge clk);
			check(holdFetch, i == st);
		end
	endtask : run_ins

	task hz(input logic [3:0] d, input amode_t dm, input ikind_t k,
		input logic [15:0] p, input logic [3:0] s, input amode_t sm);
		exDstReg = d;
		exDstMode = dm;
		exKind = k;
		exPtrVal = p;
		pfSrcReg = s;
		pfSrcMode = sm;
		pfValid = 1'b1;
		run_ins(1, exp_hit(d, dm, k, p, s, sm) ? 0 : -1);
	endtask : hz

	// Every mode pair back to back, then pointer and flow cases
	task hz_table;
		for (int i = 0; i < 16; i++) begin
			hz(4'h2, amode_t'(i[3:2]), IK_PLAIN, 16'h1000, 4'h2,
				amode_t'(i[1:0]));
		end
		hz(4'h2, AM_IND, IK_PLAIN, 16'h0004, 4'h2, AM_IND);
		hz(4'h2, AM_IND, IK_PLAIN, 16'h0004, 4'h2, AM_IND_MOD);
		hz(4'h2, AM_IND_MOD, IK_PLAIN, 16'h1000, 4'h3, AM_IND);
		hz(4'h0, AM_NONE, IK_CALL, 16'h1000, 4'hf, AM_IND);
		hz(4'h0, AM_NONE, IK_CALL, 16'h1000, 4'hf, AM_DIRECT);
		hz(4'h0, AM_NONE, IK_CALL, 16'h1000, 4'hf, AM_IND_MOD);
		hz(4'hf, AM_DIRECT, IK_JUMP, 16'h1000, 4'hf, AM_IND);
		hz(4'hf, AM_DIRECT, IK_RET, 16'h1000, 4'hf, AM_IND_MOD);
	endtask : hz_table

	// Program-space reader, then dependent multi-cycle instructions
	task pgm_stall;
		exPgmRd = 1'b1;
		pfValid = 1'b0;
		run_ins(1, -1);
		exPgmRd = 1'b0;
		pfValid = 1'b1;
		exKind = IK_PLAIN;
		exDstReg = 4'h5;
		exDstMode = AM_DIRECT;
		pfSrcReg = 4'h5;
		pfSrcMode = AM_IND;
		run_ins(3, 1);
		run_ins(2, 1);
	endtask : pgm_stall

	task acc(input logic wr, input logic byt, input logic [15:0] a, wd,
		old, res, rx);
		logic bad;
		logic [1:0] be;
		bad = !byt && a[0];
		be = byt ? (a[0] ? BE_HI : BE_LO) : BE_WORD;
		accValid = 1'b1;
		accWrite = wr;
		accByte = byt;
		accAddr = a;
		accWdata = wd;
		regOld = old;
		aluRes = res;
		exStart = 1'b1;
		exLast = 1'b1;
		pfValid = 1'b0;
		@(posedge clk);
		@(negedge clk);
		accValid = 1'b0;
		exStart = 1'b0;
		exLast = 1'b0;
		check(memEn, !(wr && bad));
		check(memWe, wr && !bad);
		if (!(wr && bad)) begin
			check(memAddr, {a[15:1], 1'b0});
			check(memBe, be);
		end
		if (wr && !bad) check(memWdata, byt ? {2{wd[7:0]}} : wd);
		check(regWrData, byt ? {old[15:8], res[7:0]} : res);
		check(flagZ, byt ? res[7:0] == 8'h00 : res == 16'h0000);
		check(flagN, byt ? res[7] : res[15]);
		check(addrErrTrap, bad);
		// Let the read pipe drain so the next request starts two cycles later
		repeat (2) @(negedge clk);
		check(rdValid, !wr);
		if (!wr) check(rdData, rx);
	endtask : acc

	task byte_word;
		acc(1, 0, 16'h1000, 16'h1234, 16'h0000, 16'h0000, 16'h0000);
		acc(1, 1, 16'h1001, 16'h0056, 16'h1234, 16'h0080, 16'h0000);
		acc(0, 0, 16'h1000, 16'h0000, 16'h0000, 16'h8000, 16'h5634);
		acc(0, 1, 16'h1001, 16'h0000, 16'h1234, 16'hff00, 16'h0056);
		acc(0, 1, 16'h1000, 16'h0000, 16'habcd, 16'h0001, 16'h0034);
		acc(1, 0, 16'h1002, 16'h6666, 16'h0000, 16'h0001, 16'h0000);
		acc(0, 0, 16'h1001, 16'h0000, 16'h0000, 16'h0001, 16'h5634);
		acc(1, 0, 16'h1003, 16'h1234, 16'h0000, 16'h0001, 16'h0000);
		acc(0, 0, 16'h1002, 16'h0000, 16'h0000, 16'h0001, 16'h6666);
	endtask : byte_word

	// Odd word access in the first of two cycles traps only at the end
	task trap_late;
		accValid = 1'b1;
		accWrite = 1'b0;
		accByte = 1'b0;
		accAddr = 16'h1005;
		exStart = 1'b1;
		exLast = 1'b0;
		@(posedge clk);
		@(negedge clk);
		accValid = 1'b0;
		exStart = 1'b0;
		exLast = 1'b1;
		check(addrErrTrap, 1'b0);
		@(posedge clk);
		@(negedge clk);
		exLast = 1'b0;
		check(addrErrTrap, 1'b1);
		@(posedge clk);
		@(negedge clk);
		check(addrErrTrap, 1'b0);
	endtask : trap_late

	// Odd word read in a stalling instruction: stall first, trap after it
	task stall_trap;
		exDstReg = 4'h2;
		exDstMode = AM_DIRECT;
		exKind = IK_PLAIN;
		pfSrcReg = 4'h2;
		pfSrcMode = AM_IND;
		pfValid = 1'b1;
		accValid = 1'b1;
		accWrite = 1'b0;
		accByte = 1'b0;
		accAddr = 16'h1007;
		exStart = 1'b1;
		exLast = 1'b1;
		@(posedge clk);
		@(negedge clk);
		accValid = 1'b0;
		exStart = 1'b0;
		check(holdFetch, 1'b1);
		check(addrErrTrap, 1'b0);
		@(posedge clk);
		@(negedge clk);
		exLast = 1'b0;
		pfValid = 1'b0;
		check(holdFetch, 1'b0);
		check(addrErrTrap, 1'b1);
	endtask : stall_trap

	// Main sequence
	initial begin
		mismatches = 0;
		compares = 0;
		cycles = 0;
		rst_b = 1'b0;
		exStart = 1'b0;
		exLast = 1'b0;
		exPgmRd = 1'b0;
		exDstReg = 4'h0;
		exDstMode = AM_NONE;
		exKind = IK_PLAIN;
		exPtrVal = 16'h0000;
		pfValid = 1'b0;
		pfSrcReg = 4'h0;
		pfSrcMode = AM_NONE;
		accValid = 1'b0;
		accWrite = 1'b0;
		accByte = 1'b0;
		accAddr = 16'h0000;
		accWdata = 16'h0000;
		regOld = 16'h0000;
		aluRes = 16'h0000;
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		check(holdFetch, 1'b0);
		check(memEn, 1'b0);
		check(addrErrTrap, 1'b0);
		hz_table;
		pgm_stall;
		byte_word;
		trap_late;
		stall_trap;
		end_of_test;
	end
endmodule : raw_stall_and_byte_word_access_tb
